// >>> hdl/tpds_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Event-active bit set on reported tap, resets 0
// - Per-axis hit bits show which axes tapped
// - Double-tap bit tells single from double
// - Per-axis sign bit: 0 positive, 1 negative
// - With latch on, set event freezes status
// - Reading status clears it and the interrupt
// - Separate read/write threshold per axis
// - Pulse detection starts above axis threshold
// - Thresholds are 7 bits, top bit reads 0
// - Codes step 0.063 g on fixed 8 g
// - Low-noise bit caps threshold at 4 g
// - Pulse valid only if it ends within limit
// - Limit counts steps, up to 255 steps
// - Step picked by rate, mode and filter
// - Filter-on step table per rate and mode
// - Filter-off step table per rate and mode
// - Filter enable comes from its control bit
// - Flags latch only with latch enable set
// - Events need per-axis single/double enable
// - Pulses ignored during latency after first
// - Second pulse must start inside window
module tpds_core import tpds_pkg::*; #(
	parameter int STEP_CYCLES = BASE_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register access
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	// Samples and operating mode
	input wire tpds_accel_t accelSample,
	input wire logic sampleValid,
	input wire logic [2:0] outputDataRate,
	input wire tpds_mode_t overSampleMode,
	input wire logic pulseLowpassEnable,
	input wire logic lowNoiseEnable,
	// Event output
	output logic tapInt
);
	generate
		if (STEP_CYCLES < 2) begin : g_bad_step
			$error("STEP_CYCLES must be at least 2");
		end
	endgenerate

	function automatic logic [3:0] stepShift(
		input logic [2:0] output_data_rate,
		input tpds_mode_t mode,
		input logic lpf
	);
		logic [3:0] r;
		logic slow;
		slow = output_data_rate > ODR_50;
		r = {1'b0, output_data_rate};
		if (lpf) begin
			r = r + EXP_ONE;
			unique case (mode)
				MODE_NORMAL: if (slow) r = EXP_NORMAL_LPF;
				MODE_LOW_POWER_LOW_NOISE: if (slow) r = EXP_SLOW_LPF;
				MODE_HIGH_RESOLUTION: if (r > EXP_HIRES_LPF) r = EXP_HIRES_LPF;
				MODE_LOW_POWER: begin
					if (slow) begin
						r = (output_data_rate == ODR_12P5) ? EXP_SLOW_LPF : EXP_LP_SLOWEST_LPF;
					end
				end
			endcase
		end else begin
			unique case (mode)
				MODE_NORMAL: begin
					if (output_data_rate != ODR_800) r = r - EXP_ONE;
					if (r > EXP_NORMAL) r = EXP_NORMAL;
				end
				MODE_LOW_POWER_LOW_NOISE: begin
					if (output_data_rate != ODR_800) r = r - EXP_ONE;
					if (slow) r = EXP_LOW_POWER_LOW_NOISE_MODE_SLOW;
				end
				MODE_HIGH_RESOLUTION: r = EXP_HIRES;
				MODE_LOW_POWER: if (slow) r = EXP_LP_SLOW;
			endcase
		end
		return r;
	endfunction : stepShift

	function automatic logic axisOver(
		input logic [7:0] s,
		input logic [6:0] ths,
		input logic lowNoise
	);
		logic [7:0] mag;
		logic [6:0] lim;
		mag = s[7] ? 8'(-s) : s;
		lim = (lowNoise && ths > LOWNOISE_THS_MAX) ? LOWNOISE_THS_MAX : ths;
		return mag > {1'b0, lim};
	endfunction : axisOver

	tpds_cfg_t cfg;
	tpds_status_t status;
	tpds_state_t state;
	tpds_state_t next_state;
	logic [6:0] xThresholdField;
	logic [6:0] yThresholdField;
	logic [6:0] zThresholdField;
	logic [7:0] pulseTimeLimit;
	logic [7:0] tapLatencyLimit;
	logic [7:0] secondTapWindow;
	logic [31:0] baseCount;
	logic [8:0] stepDiv;
	logic [7:0] phaseCount;
	logic [2:0] trackAxes;
	logic [2:0] trackSigns;

	// Sample comparison
	wire logic [2:0] overMask = {
		axisOver(accelSample.z, zThresholdField, lowNoiseEnable),
		axisOver(accelSample.y, yThresholdField, lowNoiseEnable),
		axisOver(accelSample.x, xThresholdField, lowNoiseEnable)
	};
	wire logic [2:0] signMask = {
		accelSample.z[7], accelSample.y[7], accelSample.x[7]
	};
	wire logic anyOver = |overMask;
	wire logic trackedLow = ~|(overMask & trackAxes);
	wire logic [2:0] singleEn = {cfg.zSingle, cfg.ySingle, cfg.xSingle};
	wire logic [2:0] doubleEn = {cfg.zDouble, cfg.yDouble, cfg.xDouble};

	// Step timing
	wire logic [3:0] stepExp = stepShift(outputDataRate, overSampleMode,
		pulseLowpassEnable);
	wire logic [8:0] stepMask = 9'((9'h001 << stepExp) - 9'h001);
	wire logic baseTick = baseCount == 32'(STEP_CYCLES - 1);
	wire logic stepTick = baseTick && ((stepDiv & stepMask) == stepMask);
	wire logic restart = next_state != state;
	logic [7:0] limitSel;
	always_comb begin
		unique case (state)
			ST_FIRST, ST_SECOND: limitSel = pulseTimeLimit;
			ST_LATENCY: limitSel = tapLatencyLimit;
			ST_WINDOW: limitSel = secondTapWindow;
			ST_IDLE, ST_SETTLE: limitSel = RESET_BYTE;
			default: limitSel = RESET_BYTE;
		endcase
	end
	wire logic expired = phaseCount == limitSel;

	// Detection sequence
	logic evt;
	logic evtDouble;
	logic [2:0] evtAxes;
	always_comb begin
		next_state = state;
		evt = 1'b0;
		evtDouble = 1'b0;
		evtAxes = 3'h0;
		unique case (state)
			ST_IDLE: begin
				if (sampleValid && anyOver) next_state = ST_FIRST;
			end
			ST_FIRST: begin
				if (expired) begin
					next_state = ST_SETTLE;
				end else if (sampleValid && trackedLow) begin
					evtAxes = trackAxes & singleEn;
					evt = |evtAxes;
					next_state = ST_LATENCY;
				end
			end
			ST_LATENCY: begin
				if (expired) begin
					next_state = |(trackAxes & doubleEn) ? ST_WINDOW : ST_SETTLE;
				end
			end
			ST_WINDOW: begin
				if (expired) begin
					next_state = ST_SETTLE;
				end else if (sampleValid && anyOver) begin
					next_state = ST_SECOND;
				end
			end
			ST_SECOND: begin
				if (expired) begin
					next_state = ST_SETTLE;
				end else if (sampleValid && trackedLow) begin
					evtAxes = trackAxes & doubleEn;
					evt = |evtAxes;
					evtDouble = 1'b1;
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (sampleValid && !anyOver) next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			trackAxes <= 3'h0;
			trackSigns <= 3'h0;
		end else begin
			state <= next_state;
			if (next_state == ST_FIRST || next_state == ST_SECOND) begin
				if (restart) begin
					trackAxes <= overMask;
					trackSigns <= signMask;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			baseCount <= 32'h0000_0000;
			stepDiv <= 9'h000;
			phaseCount <= RESET_BYTE;
		end else if (restart) begin
			baseCount <= 32'h0000_0000;
			stepDiv <= 9'h000;
			phaseCount <= RESET_BYTE;
		end else begin
			baseCount <= baseTick ? 32'h0000_0000 : baseCount + 32'h0000_0001;
			if (baseTick) stepDiv <= stepDiv + 9'h001;
			if (stepTick && !expired) begin
				phaseCount <= phaseCount + 8'h01;
			end
		end
	end

	// Status register
	wire logic statusRead = regRead && regAddr == ADDR_TAP_STATUS;
	wire logic frozen = status.eventActiveFlag && cfg.flagLatchEnable;
	wire tpds_status_t evtStatus = '{
		eventActiveFlag: 1'b1,
		zAxisHit: evtAxes[2],
		yAxisHit: evtAxes[1],
		xAxisHit: evtAxes[0],
		doubleTapFlag: evtDouble,
		zSign: trackSigns[2] & evtAxes[2],
		ySign: trackSigns[1] & evtAxes[1],
		xSign: trackSigns[0] & evtAxes[0]
	};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status <= tpds_status_t'(RESET_BYTE);
		end else if (evt && (!frozen || statusRead)) begin
			status <= evtStatus;
		end else if (statusRead) begin
			status <= tpds_status_t'(RESET_BYTE);
		end
	end
	assign tapInt = status.eventActiveFlag;

	// Register writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg <= tpds_cfg_t'(RESET_BYTE);
			xThresholdField <= THS_RESET;
			yThresholdField <= THS_RESET;
			zThresholdField <= THS_RESET;
			pulseTimeLimit <= RESET_BYTE;
			tapLatencyLimit <= RESET_BYTE;
			secondTapWindow <= RESET_BYTE;
		end else if (regWrite) begin
			unique case (regAddr)
				ADDR_TAP_CFG: cfg <= tpds_cfg_t'(regWdata);
				ADDR_X_THS: xThresholdField <= regWdata[6:0];
				ADDR_Y_THS: yThresholdField <= regWdata[6:0];
				ADDR_Z_THS: zThresholdField <= regWdata[6:0];
				ADDR_TIME_LIMIT: pulseTimeLimit <= regWdata;
				ADDR_LATENCY: tapLatencyLimit <= regWdata;
				ADDR_WINDOW: secondTapWindow <= regWdata;
				default: ;
			endcase
		end
	end

	// Register reads
	logic [7:0] readMux;
	always_comb begin
		unique case (regAddr)
			ADDR_TAP_CFG: readMux = cfg;
			ADDR_TAP_STATUS: readMux = status;
			ADDR_X_THS: readMux = {1'b0, xThresholdField};
			ADDR_Y_THS: readMux = {1'b0, yThresholdField};
			ADDR_Z_THS: readMux = {1'b0, zThresholdField};
			ADDR_TIME_LIMIT: readMux = pulseTimeLimit;
			ADDR_LATENCY: readMux = tapLatencyLimit;
			ADDR_WINDOW: readMux = secondTapWindow;
			default: readMux = RESET_BYTE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdata <= RESET_BYTE;
		end else if (regRead) begin
			regRdata <= readMux;
		end
	end
endmodule : tpds_core
`default_nettype wire

// >>> hdl/tpds_pkg.sv
`default_nettype none
package tpds_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_TAP_CFG = 8'h21;
	localparam logic [7:0] ADDR_TAP_STATUS = 8'h22;
	localparam logic [7:0] ADDR_X_THS = 8'h23;
	localparam logic [7:0] ADDR_Y_THS = 8'h24;
	localparam logic [7:0] ADDR_Z_THS = 8'h25;
	localparam logic [7:0] ADDR_TIME_LIMIT = 8'h26;
	localparam logic [7:0] ADDR_LATENCY = 8'h27;
	localparam logic [7:0] ADDR_WINDOW = 8'h28;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] THS_RESET = 7'h00;
	// Highest threshold code reaching 4 g at 0.063 g per code
	localparam logic [6:0] LOWNOISE_THS_MAX = 7'h3F;

	// Timing: base step of 0.625 ms at a 125 MHz clock
	localparam int CLK_PERIOD_PS = 8000;
	localparam int BASE_STEP_PS = 625000000;
	localparam int BASE_STEP_CYCLES = BASE_STEP_PS / CLK_PERIOD_PS;

	// Output data rate codes
	localparam logic [2:0] ODR_800 = 3'h0;
	localparam logic [2:0] ODR_50 = 3'h4;
	localparam logic [2:0] ODR_12P5 = 3'h5;

	// Step exponents (step = base step times two to the exponent)
	localparam logic [3:0] EXP_ONE = 4'h1;
	localparam logic [3:0] EXP_HIRES_LPF = 4'h2;
	localparam logic [3:0] EXP_NORMAL_LPF = 4'h5;
	localparam logic [3:0] EXP_SLOW_LPF = 4'h7;
	localparam logic [3:0] EXP_LP_SLOWEST_LPF = 4'h8;
	localparam logic [3:0] EXP_HIRES = 4'h0;
	localparam logic [3:0] EXP_NORMAL = 4'h3;
	localparam logic [3:0] EXP_LOW_POWER_LOW_NOISE_MODE_SLOW = 4'h5;
	localparam logic [3:0] EXP_LP_SLOW = 4'h6;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_LOW_POWER_LOW_NOISE = 2'h1,
		MODE_HIGH_RESOLUTION = 2'h2,
		MODE_LOW_POWER = 2'h3
	} tpds_mode_t;

	typedef struct packed {
		logic [7:0] z;
		logic [7:0] y;
		logic [7:0] x;
	} tpds_accel_t;

	typedef struct packed {
		logic abortDouble;
		logic flagLatchEnable;
		logic zDouble;
		logic zSingle;
		logic yDouble;
		logic ySingle;
		logic xDouble;
		logic xSingle;
	} tpds_cfg_t;

	typedef struct packed {
		logic eventActiveFlag;
		logic zAxisHit;
		logic yAxisHit;
		logic xAxisHit;
		logic doubleTapFlag;
		logic zSign;
		logic ySign;
		logic xSign;
	} tpds_status_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_FIRST = 6'h02,
		ST_LATENCY = 6'h04,
		ST_WINDOW = 6'h08,
		ST_SECOND = 6'h10,
		ST_SETTLE = 6'h20
	} tpds_state_t;
endpackage : tpds_pkg
`default_nettype wire

// >>> testbench/test_tap_pulse_detect_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_tap_pulse_detect_status import tpds_pkg::*; ;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [7:0] regAddr, regWdata, regRdata, rv;
	logic regWrite, regRead, sampleValid, lpf, lowNoise, tapInt;
	tpds_accel_t accel;
	logic [2:0] output_data_rate;
	tpds_mode_t mode;
	int fail_count = 0;
	int checked = 0;
	always #4 clk = ~clk;
	tpds_core #(.STEP_CYCLES(4)) dut (.clk(clk), .nrst(nrst),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .accelSample(accel),
		.sampleValid(sampleValid), .outputDataRate(output_data_rate),
		.overSampleMode(mode), .pulseLowpassEnable(lpf),
		.lowNoiseEnable(lowNoise), .tapInt(tapInt));
	tpds_host host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// One pulse of n samples on one axis, then quiet samples
	task automatic tap(input int ax, input logic [7:0] v, input int n);
		host.idle;
		sampleValid = 1'h1;
		accel[ax*8 +: 8] = v;
		repeat (n) @(negedge clk);
		accel = '0;
		repeat (3) @(negedge clk);
		sampleValid = 1'h0;
		@(negedge clk);
	endtask : tap
	task automatic ev(input int ax, input logic [7:0] v, input int n,
		input logic [7:0] e);
		tap(ax, v, n);
		host.rd(ADDR_TAP_STATUS, rv);
		chk("status", rv, e);
	endtask : ev
	task automatic t_regs;
		logic [7:0] a;
		for (a = ADDR_X_THS; a <= ADDR_TIME_LIMIT; a++) begin
			host.rd(a, rv);
			chk("reset value", rv, RESET_BYTE);
			host.wr(a, 8'hC0 + a);
			host.rd(a, rv);
		end
		for (a = ADDR_X_THS; a <= ADDR_TIME_LIMIT; a++) begin
			host.rd(a, rv);
			chk("reg", rv, (a == ADDR_TIME_LIMIT) ? 8'hE6 : 8'h40 + a);
		end
		host.wr(ADDR_TAP_STATUS, 8'hFF);
		host.rd(ADDR_TAP_STATUS, rv);
		chk("status reset", rv, RESET_BYTE);
		host.rd(8'h30, rv);
		chk("unmapped", rv, 8'h00);
	endtask : t_regs
	task automatic t_event;
		host.wr(ADDR_TAP_CFG, 8'h01);
		host.wr(ADDR_X_THS, 8'h0A);
		host.wr(ADDR_Y_THS, 8'h0A);
		host.wr(ADDR_TIME_LIMIT, 8'h0A);
		tap(0, 8'h14, 3);
		chk("tapInt", {7'h00, tapInt}, 8'h01);
		host.rd(ADDR_TAP_STATUS, rv);
		chk("status", rv, 8'h90);
		host.rd(ADDR_TAP_STATUS, rv);
		chk("cleared", rv, 8'h00);
		chk("tapInt", {7'h00, tapInt}, 8'h00);
		ev(0, 8'hEC, 3, 8'h91);
		host.wr(ADDR_TAP_CFG, 8'h04);
		ev(1, 8'h14, 3, 8'hA0);
		host.wr(ADDR_TAP_CFG, 8'h00);
		ev(0, 8'h14, 3, 8'h00);
	endtask : t_event
	task automatic t_latch;
		host.wr(ADDR_TAP_CFG, 8'h01);
		tap(0, 8'h14, 3);
		ev(0, 8'hEC, 3, 8'h91);
		host.wr(ADDR_TAP_CFG, 8'h41);
		tap(0, 8'h14, 3);
		ev(0, 8'hEC, 3, 8'h90);
	endtask : t_latch
	task automatic t_limit;
		host.wr(ADDR_TAP_CFG, 8'h01);
		host.wr(ADDR_TIME_LIMIT, 8'h01);
		ev(0, 8'h14, 6, 8'h00);
		lpf = 1'h1;
		ev(0, 8'h14, 6, 8'h90);
		lpf = 1'h0;
		host.wr(ADDR_TIME_LIMIT, 8'h02);
		ev(0, 8'h14, 6, 8'h90);
		host.wr(ADDR_TIME_LIMIT, 8'h0A);
	endtask : t_limit
	task automatic t_thresh;
		host.wr(ADDR_TAP_CFG, 8'h10);
		host.wr(ADDR_Z_THS, 8'h0A);
		ev(2, 8'h0A, 3, 8'h00);
		ev(2, 8'h0B, 3, 8'hC0);
		ev(2, 8'hF6, 3, 8'h00);
		ev(2, 8'hF5, 3, 8'hC4);
		host.wr(ADDR_TAP_CFG, 8'h01);
		host.wr(ADDR_X_THS, 8'h64);
		ev(0, 8'h46, 3, 8'h00);
		lowNoise = 1'h1;
		ev(0, 8'h46, 3, 8'h90);
		lowNoise = 1'h0;
		host.wr(ADDR_X_THS, 8'h0A);
	endtask : t_thresh
	task automatic t_double;
		host.wr(ADDR_TAP_CFG, 8'h02);
		host.wr(ADDR_WINDOW, 8'h20);
		tap(0, 8'h14, 3);
		chk("tapInt", {7'h00, tapInt}, 8'h00);
		ev(0, 8'h14, 3, 8'h98);
	endtask : t_double
	// A pulse inside the latency interval must not replace the first event
	task automatic t_latency;
		host.wr(ADDR_TAP_CFG, 8'h01);
		host.wr(ADDR_LATENCY, 8'h04);
		tap(0, 8'h14, 3);
		ev(0, 8'hEC, 3, 8'h90);
		tap(0, 8'h00, 12);
		host.wr(ADDR_LATENCY, RESET_BYTE);
	endtask : t_latency
	// Slower rates and other modes change the time-limit step
	task automatic t_rate;
		host.wr(ADDR_TAP_CFG, 8'h01);
		host.wr(ADDR_TIME_LIMIT, 8'h01);
		output_data_rate = ODR_50;
		ev(0, 8'h14, 6, 8'h90);
		mode = MODE_HIGH_RESOLUTION;
		ev(0, 8'h14, 6, 8'h00);
		lpf = 1'h1;
		ev(0, 8'h14, 6, 8'h90);
		lpf = 1'h0;
		mode = MODE_NORMAL;
		output_data_rate = ODR_800;
		host.wr(ADDR_TIME_LIMIT, 8'h0A);
	endtask : t_rate
	// Reset in mid-run drops a pending event and the registers
	task automatic t_reset;
		host.wr(ADDR_TAP_CFG, 8'h41);
		tap(0, 8'h14, 3);
		chk("tapInt", {7'h00, tapInt}, 8'h01);
		nrst = 1'h0;
		@(negedge clk);
		nrst = 1'h1;
		@(negedge clk);
		chk("tapInt", {7'h00, tapInt}, 8'h00);
		host.rd(ADDR_TAP_STATUS, rv);
		chk("status", rv, RESET_BYTE);
		host.rd(ADDR_TAP_CFG, rv);
		chk("config", rv, RESET_BYTE);
		host.rd(ADDR_X_THS, rv);
		chk("threshold", rv, RESET_BYTE);
	endtask : t_reset
	initial begin
		accel = '0;
		sampleValid = 1'h0;
		output_data_rate = ODR_800;
		mode = MODE_NORMAL;
		lpf = 1'h0;
		lowNoise = 1'h0;
		repeat (2) @(negedge clk);
		nrst = 1'h1;
		@(negedge clk);
		t_regs;
		t_event;
		t_latch;
		t_latency;
		t_limit;
		t_rate;
		t_thresh;
		t_double;
		t_reset;
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim;
	end
endmodule : test_tap_pulse_detect_status
bind tpds_core tpds_checker u_chk (.clk(clk), .nrst(nrst),
	.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.regRead(regRead), .regRdata(regRdata), .sampleValid(sampleValid),
	.tapInt(tapInt));
`default_nettype wire

// >>> testbench/tpds_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tpds_checker import tpds_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register access
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	// Samples and event
	input wire logic sampleValid,
	input wire logic tapInt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic stRd = regRead && regAddr == ADDR_TAP_STATUS;
	wire logic thRd = regRead && regAddr >= ADDR_X_THS && regAddr <= ADDR_Z_THS;
	sequence s_ths_wr_rd;
		regWrite && regAddr == ADDR_X_THS ##1 regRead && regAddr == ADDR_X_THS;
	endsequence
	sequence s_tl_wr_rd;
		regWrite && regAddr == ADDR_TIME_LIMIT ##1
			regRead && regAddr == ADDR_TIME_LIMIT;
	endsequence
	property p_clear;
		stRd && !sampleValid && !$past(sampleValid) |=> !tapInt;
	endproperty
	property p_rd_flag;
		stRd |=> regRdata[7] == $past(tapInt);
	endproperty
	property p_rise;
		$rose(tapInt) |-> $past(sampleValid) || $past(sampleValid, 2);
	endproperty
	property p_fall;
		$fell(tapInt) |-> $past(stRd);
	endproperty
	property p_ths_top;
		thRd |=> !regRdata[7];
	endproperty
	property p_unmapped;
		regRead && regAddr > ADDR_WINDOW |=> regRdata == 8'h00;
	endproperty
	property p_ths_rw;
		s_ths_wr_rd |=> regRdata == {1'h0, $past(regWdata[6:0], 2)};
	endproperty
	property p_tl_rw;
		s_tl_wr_rd |=> regRdata == $past(regWdata, 2);
	endproperty
	a_clear: assert property (p_clear)
		else $error("tap flag not cleared by status read");
	a_rd_flag: assert property (p_rd_flag)
		else $error("event bit differs from tap flag");
	a_rise: assert property (p_rise)
		else $error("tap flag rose without a sample");
	a_fall: assert property (p_fall)
		else $error("tap flag fell without status read");
	a_ths_top: assert property (p_ths_top)
		else $error("threshold top bit not zero");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_ths_rw: assert property (p_ths_rw)
		else $error("threshold readback wrong");
	a_tl_rw: assert property (p_tl_rw)
		else $error("time limit readback wrong");
endmodule : tpds_checker
`default_nettype wire

// >>> testbench/tpds_host.sv
`timescale 1ns/1ps
`default_nettype none
module tpds_host (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWrite,
	output logic regRead,
	input wire logic [7:0] regRdata
);
	initial begin
		regAddr = 8'h00;
		regWdata = 8'h00;
		regWrite = 1'h0;
		regRead = 1'h0;
	end
	// Access tasks leave their strobe up, so back-to-back accesses never
	// lower and raise one strobe in the same step; idle drops both
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWdata = d;
		regRead = 1'h0;
		regWrite = 1'h1;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regAddr = a;
		regWrite = 1'h0;
		regRead = 1'h1;
		@(negedge clk);
		d = regRdata;
	endtask : rd
	task automatic idle;
		regWrite = 1'h0;
		regRead = 1'h0;
	endtask : idle
endmodule : tpds_host
`default_nettype wire
